// ==== logic/mft_pkg.sv ====
// register map, field layout and types of the multifunction timer core
package mft_pkg;
  // bus address and response codes
  typedef logic [11:0] mft_addr_t;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CL0H = 8'hf0;
  localparam logic [7:0] IDX_CL0L = 8'hf1;
  localparam logic [7:0] IDX_CL1H = 8'hf2;
  localparam logic [7:0] IDX_CL1L = 8'hf3;
  localparam logic [7:0] IDX_CM0H = 8'hf4;
  localparam logic [7:0] IDX_CM0L = 8'hf5;
  localparam logic [7:0] IDX_CM1H = 8'hf6;
  localparam logic [7:0] IDX_CM1L = 8'hf7;
  localparam logic [7:0] IDX_CTRL = 8'hf8;
  localparam logic [7:0] IDX_MODE = 8'hf9;
  localparam logic [7:0] IDX_ICR  = 8'hfa;
  localparam logic [7:0] IDX_PRE  = 8'hfb;
  localparam int         NREG     = 12;
  // counter_control bits
  localparam int B_CEN = 7;
  localparam int B_CCP = 6;
  localparam int B_CCM = 5;
  localparam int B_CCL = 4;
  localparam int B_UDC = 3;
  // mode_select bits
  localparam int B_OEB = 7;
  localparam int B_OEA = 6;
  localparam int B_BM  = 5;
  localparam int B_RM1 = 4;
  localparam int B_RM0 = 3;
  localparam int B_ECK = 2;
  localparam int B_REN = 1;
  localparam int B_CO  = 0;
  // input_pin_control fields and edge code bits
  localparam int INF_HI = 7;
  localparam int INF_LO = 4;
  localparam int EA_LO  = 2;
  localparam int EB_LO  = 0;
  localparam int E_RISE = 1;
  localparam int E_FALL = 0;
  // reset values, count limit and step
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  // operating modes
  typedef enum logic [2:0] {
    M_BILOAD, M_BICAP, M_LOAD_MON, M_LOAD_CAP, M_CAP_MON, M_CAP_CAP
  } mft_mode_e;
  // roles of the two input pins
  typedef struct packed {
    logic a_gate, a_trig, a_clk, a_dir;
    logic b_gate, b_trig, b_clk;
    logic ud_pins, ud_clk;
  } mft_roles_s;
  // decoded register address
  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
  } mft_dec_s;
endpackage

// ==== logic/mft_edge.sv ====
// input pin synchroniser with selectable edge detection
`timescale 1ns/1ns
module mft_edge (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pin and edge selection
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  // synchronised level and edge event
  output logic            lvl,
  output logic            evt
);
  import mft_pkg::*;
  logic [2:0] sh_q;  // two sync stages then history
  // shift the pin through the synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) sh_q <= 3'h0;
    else sh_q <= {sh_q[1:0], pin};
  end
  assign lvl = sh_q[1];
  assign evt = (edge_sel[E_RISE] & sh_q[1] & ~sh_q[2])
             | (edge_sel[E_FALL] & ~sh_q[1] & sh_q[2]);
endmodule

// ==== logic/mft_presc.sv ====
// 8-bit down prescaler giving a one-cycle count enable
`timescale 1ns/1ns
module mft_presc #(
  parameter int W = 8  // prescaler width
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         en,
  input  wire logic         reload,
  input  wire logic [W-1:0] preset,
  // divided enable
  output logic              tick
);
  logic [W-1:0] cnt_q;  // remaining input events
  // zero count ends a period of preset plus one
  assign tick = en & (cnt_q == '0);
  // preset taken only on underflow or reload
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= '0;  // divide by one
    else if (reload || tick) cnt_q <= preset;
    else if (en) cnt_q <= cnt_q - 1'b1;
  end
endmodule

// ==== logic/mft_core.sv ====
// multifunction up/down timer core with axi4-lite register file
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module mft_core #(
  parameter bit PARALLEL_OK = 1'b0  // instance has a parallel clock source
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire mft_pkg::mft_addr_t awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire mft_pkg::mft_addr_t araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // timer pins
  input  wire logic              timer_input_a,
  input  wire logic              timer_input_b,
  output logic                   timer_output_a,
  output logic                   timer_output_b,
  // links to the rest of the timer
  input  wire logic              global_count_gate,
  input  wire logic              out_a_level,
  input  wire logic              out_b_level,
  input  wire logic              par_tick,
  // events for the flag and action logic
  output logic                   match0_evt,
  output logic                   match1_evt,
  output logic                   wrap_evt,
  output logic                   cap0_evt,
  output logic                   cap1_evt
);
  import mft_pkg::*;

  // address decode, shared by read and write paths
  function automatic mft_dec_s dec(input mft_addr_t a);
    mft_dec_s d;
    d.hit = (a[11:10] == 2'h0) && (a[9:2] >= IDX_CL0H) && (a[9:2] <= IDX_PRE);
    d.idx = a[5:2];
    return d;
  endfunction

  function automatic mft_roles_s roles_of(input logic [3:0] f);
    mft_roles_s r;
    r = '0;
    case (f)
      4'h1: r.b_trig = 1'b1;
      4'h2: r.a_gate = 1'b1;
      4'h3: begin
        r.a_gate = 1'b1;
        r.b_trig = 1'b1;
      end
      4'h4: r.b_clk = 1'b1;
      4'h5: r.a_trig = 1'b1;
      4'h6: begin
        r.a_gate = 1'b1;
        r.b_clk  = 1'b1;
      end
      4'h7: begin
        r.a_trig = 1'b1;
        r.b_trig = 1'b1;
      end
      4'h8, 4'hc: begin
        r.ud_pins = 1'b1;
        r.ud_clk  = 1'b1;
      end
      4'h9: begin
        r.a_dir = 1'b1;
        r.b_clk = 1'b1;
      end
      4'ha: begin
        r.ud_pins = 1'b1;
        r.a_trig  = 1'b1;
        r.b_trig  = 1'b1;
      end
      4'hb: r.a_dir = 1'b1;
      4'hd: begin
        r.a_trig = 1'b1;
        r.b_clk  = 1'b1;
      end
      4'he: begin
        r.a_clk  = 1'b1;
        r.b_trig = 1'b1;
      end
      4'hf: begin
        r.a_trig = 1'b1;
        r.b_gate = 1'b1;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // software registers
  logic [15:0] cl0_q, cl1_q;        // capture_load_0 and _1
  logic [15:0] cm0_q, cm1_q;        // match_value_0 and _1
  logic [7:0]  ctrl_q;              // counter_control writable bits
  logic [7:0]  mode_q;              // mode_select
  logic [7:0]  icr_q;               // input_pin_control
  logic [7:0]  pre_q;               // prescale_preset
  // timer state
  logic [15:0] cnt_q, cnt_d;        // up/down counter
  logic        armed_q;             // one-shot run permission
  logic        sel_q;               // bivalue register toggle
  logic        dir_q;               // last pin-given direction
  logic        wseen_q;             // wrap since last capture 0
  logic        of0_q;               // wrap_during_capture
  // bus state
  mft_addr_t   awa_q;               // held write address
  logic [7:0]  wd_q;                // held write byte
  logic        ws_q;                // held lane 0 strobe
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // event and pin flops
  logic        m0_q, m1_q, wrap_q, c0_q, c1_q, oa_q, ob_q;

  // pin synchronisers, one per input
  logic [1:0] pin_w, lvl_w, evt_w;
  assign pin_w = {timer_input_b, timer_input_a};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      mft_edge u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (pin_w[gi]),
        .edge_sel (gi == 0 ? icr_q[EA_LO+1:EA_LO] : icr_q[EB_LO+1:EB_LO]),
        .lvl      (lvl_w[gi]),
        .evt      (evt_w[gi])
      );
    end
  endgenerate

  // decoded controls
  mft_roles_s ro;
  mft_mode_e  mode;
  logic       bm, rm1, rm0, co, ren, par, count_enable;
  assign ro  = roles_of(icr_q[INF_HI:INF_LO]);
  assign bm  = mode_q[B_BM];
  assign rm1 = mode_q[B_RM1];
  assign rm0 = mode_q[B_RM0];
  assign co  = mode_q[B_CO];
  assign ren = mode_q[B_REN];
  assign count_enable = ctrl_q[B_CEN];
  // parallel clock only where the instance has it
  assign par = PARALLEL_OK & mode_q[B_ECK];
  // mode table, second_reg_mode unused in bivalue
  assign mode = bm ? (rm0 ? M_BICAP : M_BILOAD)
              : ({rm1, rm0} == 2'b00) ? M_LOAD_MON
              : ({rm1, rm0} == 2'b10) ? M_LOAD_CAP
              : ({rm1, rm0} == 2'b01) ? M_CAP_MON : M_CAP_CAP;

  // mode groups
  logic is_load, is_bi, mon1;
  assign is_load = (mode == M_BILOAD) | (mode == M_LOAD_MON) | (mode == M_LOAD_CAP);
  assign is_bi   = (mode == M_BILOAD) | (mode == M_BICAP);
  assign mon1    = (mode == M_LOAD_MON) | (mode == M_CAP_MON);

  logic ud_now, up;
  assign ud_now = evt_w[0] | (~evt_w[1] & dir_q);
  assign up = ro.ud_pins ? ud_now : ro.a_dir ? lvl_w[0] : ctrl_q[B_UDC];

  // gate and prescaler clock source
  logic gate_ok, clk_src, run;
  assign gate_ok = (~ro.a_gate | lvl_w[0]) & (~ro.b_gate | lvl_w[1]);
  assign clk_src = par ? par_tick
                 : ro.ud_clk ? (evt_w[0] | evt_w[1])
                 : ro.a_clk ? evt_w[0]
                 : ro.b_clk ? evt_w[1] : 1'b1;
  // local enable and global gate both needed
  assign run = count_enable & global_count_gate & gate_ok & armed_q;

  // triggers: a single trigger pin feeds register 0
  logic trg0, trg1, trg_ok;
  assign trg0 = (ro.a_trig & evt_w[0]) | (ro.b_trig & ~ro.a_trig & evt_w[1]);
  assign trg1 = ro.a_trig & ro.b_trig & evt_w[1];
  // retrigger ignored while a one-shot runs with the REN bit of mode_select set
  assign trg_ok = trg0 & ~(co & armed_q & ren);

  // prescaler and count step
  logic tick, wrap, load_req, clr_req, cap0, cap1, ccl_wr, presc_rl;
  assign presc_rl = clr_req | load_req;
  mft_presc #(.W(8)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (run & clk_src),
    .reload  (presc_rl),
    .preset  (pre_q),
    .tick    (tick)
  );
  assign wrap = tick & (up ? (cnt_q == CNT_MAX) : (cnt_q == RST_WORD));

  // captures and trigger loads do not look at count_enable
  // capture registers follow the selected mode
  assign cap0 = (trg_ok & ((mode == M_CAP_MON) | (mode == M_CAP_CAP)))
              | (trg_ok & (mode == M_BICAP) & ~sel_q);
  assign cap1 = (trg_ok & (mode == M_LOAD_CAP))
              | (trg1 & (mode == M_CAP_CAP))
              | (trg_ok & (mode == M_BICAP) & sel_q);
  // continuous mode reloads on end of count in the load modes
  assign load_req = is_load & (trg_ok | (wrap & ~co));
  assign clr_req = ccl_wr
                 | (ctrl_q[B_CCP] & (cap0 | cap1))
                 | (ctrl_q[B_CCM] & m0_q);

  // counter next value: clear, then load, then count
  always_comb begin
    cnt_d = cnt_q;
    if (clr_req) cnt_d = RST_WORD;
    else if (load_req) cnt_d = (is_bi & sel_q) ? cl1_q : cl0_q;
    else if (tick) cnt_d = up ? cnt_q + CNT_STEP : cnt_q - CNT_STEP;
  end

  // counter, one-shot and bivalue state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= RST_WORD;
      armed_q <= 1'b1;
      sel_q   <= 1'b0;
      dir_q   <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // one-shot stops at end of count, trigger rearms
      if (!co) armed_q <= 1'b1;
      else if (trg_ok) armed_q <= 1'b1;
      else if (wrap) armed_q <= 1'b0;
      if (is_bi && (load_req || cap0 || cap1)) sel_q <= ~sel_q;
      if (ro.ud_pins) dir_q <= ud_now;
    end
  end

  // wrap seen since the last register 0 capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wseen_q <= 1'b0;
      of0_q   <= 1'b0;
    end else if (cap0) begin
      wseen_q <= 1'b0;
      of0_q   <= wseen_q | wrap;
    end else begin
      wseen_q <= wseen_q | wrap;
    end
  end

  // event pulses for the flag logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {m0_q, m1_q, wrap_q, c0_q, c1_q} <= 5'h00;
    end else begin
      m0_q   <= tick & ~clr_req & ~load_req & (cnt_d == cm0_q);
      m1_q   <= tick & ~clr_req & ~load_req & (cnt_d == cm1_q);
      wrap_q <= wrap;
      c0_q   <= cap0;
      c1_q   <= cap1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oa_q <= 1'b1;
      ob_q <= 1'b1;
    end else begin
      oa_q <= mode_q[B_OEA] ? out_a_level : 1'b1;
      ob_q <= mode_q[B_OEB] ? out_b_level : 1'b1;
    end
  end

  // write path: address and data may come in either order
  logic      aw_hs, w_hs, wr_go;
  mft_dec_s  wdec, rdec;
  logic [NREG-1:0] we;
  assign aw_hs = awvalid & awready_q;
  assign w_hs  = wvalid & wready_q;
  assign wr_go = ~awready_q & ~wready_q & ~bvalid_q;
  assign wdec  = dec(awa_q);
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_we
      assign we[gi] = wr_go & wdec.hit & ws_q & (wdec.idx == 4'(gi));
    end
  endgenerate
  // clear pulse acts once; the bit kept in ctrl_q reads back as zero
  assign ccl_wr = we[IDX_CTRL[3:0]] & wd_q[B_CCL];

  // axi write handshakes and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awa_q     <= '0;
      wd_q      <= RST_BYTE;
      ws_q      <= 1'b0;
    end else begin
      if (aw_hs) begin
        awa_q     <= awaddr;
        awready_q <= 1'b0;
      end
      if (w_hs) begin
        wd_q     <= wdata[7:0];
        ws_q     <= wstrb[0];
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= RST_BYTE;
      mode_q <= RST_BYTE;
      icr_q  <= RST_BYTE;
      pre_q  <= RST_BYTE;
    end else begin
      if (we[IDX_CTRL[3:0]]) ctrl_q <= wd_q;
      if (we[IDX_MODE[3:0]]) mode_q <= wd_q;
      if (we[IDX_ICR[3:0]])  icr_q  <= wd_q;
      if (we[IDX_PRE[3:0]])  pre_q  <= wd_q;
    end
  end

  // match registers, byte halves, reset zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cm0_q <= RST_WORD;
      cm1_q <= RST_WORD;
    end else begin
      if (we[IDX_CM0H[3:0]]) cm0_q[15:8] <= wd_q;
      if (we[IDX_CM0L[3:0]]) cm0_q[7:0]  <= wd_q;
      if (we[IDX_CM1H[3:0]]) cm1_q[15:8] <= wd_q;
      if (we[IDX_CM1L[3:0]]) cm1_q[7:0]  <= wd_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cl0_q <= RST_WORD;
      cl1_q <= RST_WORD;
    end else begin
      if (cap0) cl0_q <= cnt_q;
      else begin
        if (we[IDX_CL0H[3:0]]) cl0_q[15:8] <= wd_q;
        if (we[IDX_CL0L[3:0]]) cl0_q[7:0]  <= wd_q;
      end
      if (cap1 || mon1) cl1_q <= cnt_q;
      else begin
        if (we[IDX_CL1H[3:0]]) cl1_q[15:8] <= wd_q;
        if (we[IDX_CL1L[3:0]]) cl1_q[7:0]  <= wd_q;
      end
    end
  end

  // read map; direction, wrap flag, run status
  logic [7:0] rmap [NREG];
  assign rmap[IDX_CL0H[3:0]] = cl0_q[15:8];
  assign rmap[IDX_CL0L[3:0]] = cl0_q[7:0];
  assign rmap[IDX_CL1H[3:0]] = cl1_q[15:8];
  assign rmap[IDX_CL1L[3:0]] = cl1_q[7:0];
  assign rmap[IDX_CM0H[3:0]] = cm0_q[15:8];
  assign rmap[IDX_CM0L[3:0]] = cm0_q[7:0];
  assign rmap[IDX_CM1H[3:0]] = cm1_q[15:8];
  assign rmap[IDX_CM1L[3:0]] = cm1_q[7:0];
  assign rmap[IDX_CTRL[3:0]] = {ctrl_q[B_CEN:B_CCM], 1'b0, ctrl_q[B_UDC], up, of0_q, run};
  assign rmap[IDX_MODE[3:0]] = mode_q;
  assign rmap[IDX_ICR[3:0]]  = icr_q;
  assign rmap[IDX_PRE[3:0]]  = pre_q;
  assign rdec = dec(araddr);

  // axi read: data one edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rdec.hit ? {24'h00_0000, rmap[rdec.idx]} : 32'h0000_0000;
      rresp_q   <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // outputs straight from flops
  assign awready        = awready_q;
  assign wready         = wready_q;
  assign bvalid         = bvalid_q;
  assign bresp          = bresp_q;
  assign arready        = arready_q;
  assign rvalid         = rvalid_q;
  assign rdata          = rdata_q;
  assign rresp          = rresp_q;
  assign timer_output_a = oa_q;
  assign timer_output_b = ob_q;
  assign match0_evt     = m0_q;
  assign match1_evt     = m1_q;
  assign wrap_evt       = wrap_q;
  assign cap0_evt       = c0_q;
  assign cap1_evt       = c1_q;
endmodule

// ==== verif/mft_core_assertions.sv ====
// port-level checks of the timer core
`timescale 1ns/1ns
module mft_core_assertions
  import mft_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // timer side
  input wire logic        global_count_gate,
  input wire logic        timer_output_a,
  input wire logic        timer_output_b,
  input wire logic        wrap_evt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken at one edge
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // count gate held low long enough to freeze stepping
  sequence s_gate_off;
    !global_count_gate [*4];
  endsequence
  property p_wr_lat;
    s_wr_take |=> !bvalid ##[1:2] bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response timing wrong");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_lat;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_busy;
    rvalid |-> !arready && rdata[31:8] == 24'h00_0000;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read channel state wrong");
  property p_err_zero;
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read gave data");
  property p_rst;
    $rose(aresetn) |-> timer_output_a && timer_output_b && !bvalid && !rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_gate;
    s_gate_off |-> !wrap_evt;
  endproperty
  a_gate: assert property (p_gate) else $error("wrap while gated");
endmodule

bind mft_core mft_core_assertions u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .global_count_gate,
  .timer_output_a, .timer_output_b, .wrap_evt);

// ==== verif/tb.sv ====
// self-checking bench of the timer core
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %h got %h", n, e, g); end end
module tb;
  import mft_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tin_b, gate;
  logic        out_a, out_b, lvl_a, lvl_b, m0, m1, c0, c1, wrp, tin_a;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [7:0]  rd_v;
  mft_addr_t   awaddr, araddr;
  int          n_mismatch, checks, n, c;
  wire  [4:0]  evs = {c1, wrp, c0, m1, m0};
  mft_core dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .timer_input_a(tin_a),
    .timer_input_b(tin_b), .timer_output_a(out_a), .timer_output_b(out_b), .global_count_gate(gate),
    .out_a_level(lvl_a), .out_b_level(lvl_b), .par_tick(1'b0), .match0_evt(m0), .match1_evt(m1),
    .wrap_evt(wrp), .cap0_evt(c0), .cap1_evt(c1));
  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a spent wait bound ends the run
  task automatic tmo(input bit bad);
    if (bad) begin
      n_mismatch++;
      results();
    end
  endtask
  // one bus write, response code into rsp
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [3:0] s = 4'hf);
    int k;
    bit a, w;
    a = 0; w = 0; k = 0;
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      k++;
      if (awready) begin a = 1; awvalid <= 1'b0; end
      if (wready) begin w = 1; wvalid <= 1'b0; end
    end while (!(a && w) && k < 60);
    do begin @(posedge aclk); k++; end while (!bvalid && k < 60);
    rsp = bresp;
    bready <= 1'b0;
    tmo(k >= 60);
    @(posedge aclk);
  endtask
  // one bus read, byte into rd_v
  task automatic rd(input logic [7:0] ix);
    int k;
    k = 0;
    araddr <= {2'b00, ix, 2'b00};
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 60);
    rd_v = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
    tmo(k >= 60);
    @(posedge aclk);
  endtask
  // count cycles until event s is seen
  task automatic wev(input int s);
    n = 0;
    do begin @(posedge aclk); n++; end while (!evs[s] && n < 200);
    tmo(n >= 200);
  endtask
  task automatic t_reset;
    for (int i = 0; i < NREG; i++) begin
      rd(IDX_CL0H + 8'(i));
      `CHK("reset value", RST_BYTE, rd_v)
    end
    `CHK("idle outputs", 2'b11, {out_a, out_b})
    rd(8'hfc);
    `CHK("unmapped read", RESP_SLVERR, rsp)
    $display("test reset done");
  endtask
  task automatic t_count;
    wr(IDX_CM0L, 8'h04);
    wr(IDX_CM1L, 8'h08);
    wr(IDX_CTRL, 8'h88);
    gate <= 1'b1;
    wev(0);
    // a gated stretch must freeze the count and add nothing to the match gap
    gate <= 1'b0;
    repeat (10) @(posedge aclk);
    gate <= 1'b1;
    wev(1);
    `CHK("gated gap", 4, n)
    rd(IDX_CTRL);
    `CHK("ctrl up", 8'h8d, rd_v)
    wr(IDX_PRE, 8'h02);
    wr(IDX_CTRL, 8'h98);
    wev(0);
    wev(1);
    `CHK("divided gap", 12, n)
    rd(IDX_CTRL);
    `CHK("clear reads zero", 8'h8d, rd_v)
    wr(IDX_CTRL, 8'h80);
    rd(IDX_CTRL);
    `CHK("ctrl down", 8'h81, rd_v)
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL);
    `CHK("ctrl halted", 8'h00, rd_v)
    // one-shot down count from a clear: wraps after one divided step, then halts
    wr(IDX_MODE, 8'h01);
    wr(IDX_CTRL, 8'h90);
    wev(3);
    `CHK("wrap gap", 2, n)
    rd(IDX_CTRL);
    `CHK("one-shot halt", 8'h80, rd_v)
    $display("test count done");
  endtask
  task automatic t_cap;
    int x;
    wr(IDX_MODE, 8'h08);
    wr(IDX_CL0L, 8'h5a);
    wr(IDX_CTRL, 8'h10);
    wr(IDX_ICR, 8'h12);
    tin_b <= 1'b1;
    wev(2);
    rd(IDX_CL0L);
    `CHK("capture stopped", 8'h00, rd_v)
    // the one-shot wrap is reported at this first capture
    rd(IDX_CTRL);
    `CHK("wrap flag", 8'h02, rd_v)
    tin_b <= 1'b0;
    repeat (8) @(posedge aclk);
    // each edge code against one rise and one fall
    for (int e = 0; e < 4; e++) begin
      wr(IDX_ICR, 8'h10 | 8'(e));
      c = 0;
      x = (e & 1) + (e >> 1);
      for (int h = 1; h >= 0; h--) begin
        tin_b <= h[0];
        repeat (8) begin @(posedge aclk); c += int'(c0); end
      end
      `CHK("edge events", x, c)
    end
    // load/capture mode: a trigger captures the stopped counter into register 1
    wr(IDX_MODE, 8'h10);
    wr(IDX_CL1L, 8'h33);
    tin_b <= 1'b1;
    wev(4);
    rd(IDX_CL1L);
    `CHK("capture into 1", 8'h00, rd_v)
    // pin A sets the direction over direction_select
    tin_a <= 1'b1;
    wr(IDX_ICR, 8'hb0);
    rd(IDX_CTRL);
    `CHK("pin direction", 8'h04, rd_v)
    $display("test capture done");
  endtask
  task automatic t_out;
    for (int i = 1; i < 4; i++) begin
      wr(IDX_MODE, {i[1:0], 6'h08});
      repeat (3) @(posedge aclk);
      `CHK("output force", {~i[0], ~i[1]}, {out_a, out_b})
    end
    // both enabled: pins follow the action levels
    lvl_a <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("output follows", 2'b10, {out_a, out_b})
    wr(IDX_PRE, 8'h7e);
    wr(IDX_PRE, 8'h11, 4'h0);
    rd(IDX_PRE);
    `CHK("preset kept", 8'h7e, rd_v)
    wr(8'hfc, 8'h01);
    `CHK("unmapped write", RESP_SLVERR, rsp)
    $display("test outputs done");
  endtask
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tin_a, tin_b, gate, lvl_a, lvl_b} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_count();
    t_cap();
    t_out();
    results();
  end
endmodule
